// [fbfc_link_partner.sv]
/*
 * link partner model: sends whole frames, fcs appended, one byte a cycle.
 * assumes a single caller at a time and a port on the same clock.
 */
`timescale 1ns/1ps
module fbfc_link_partner (
    // clock
    input wire logic i_clk,
    // pause request from the port
    input wire fbfc_pkg::pause_t i_pause,
    // receive stream toward the port
    output logic o_rx_valid,
    output fbfc_pkg::beat_t o_rx_beat,
    output logic o_rx_err
);
    // ------------------------------------------------------------
    // pause state
    // ------------------------------------------------------------
    logic held_q = 1'b0; // held off by the last xoff

    // a new frame waits while held, so nothing is lost in the store
    always @(posedge i_clk) begin
        if (i_pause.send) begin
            held_q <= (i_pause.quanta != 16'h0000);
        end
    end

    initial begin
        o_rx_valid = 1'b0;
        o_rx_beat = '0;
        o_rx_err = 1'b0;
    end

    // ------------------------------------------------------------
    // frame sender, called at a falling edge
    // ------------------------------------------------------------
    task automatic send(input logic [7:0] id, input int len, input bit tag,
                        input logic [2:0] prio, input bit bad, input bit err);
        logic [31:0] crc;
        logic [7:0] b;
        crc = 32'hFFFFFFFF;
        while (held_q) @(negedge i_clk);
        for (int i = 0; i < len; i++) begin
            if (i >= len - 4) begin
                // fcs goes out low byte first; a bad one flips a bit
                b = 8'(~crc >> (8 * (i - len + 4)));
                b = b ^ {7'h00, bad && i == len - 1};
            end else begin
                b = (i == 0) ? id : 8'($urandom());
                if (tag && i == 12) b = 8'h81;
                if (tag && i == 13) b = 8'h00;
                if (tag && i == 14) b = {prio, 5'h00};
                crc = crc ^ {24'h000000, b};
                for (int k = 0; k < 8; k++) begin
                    crc = crc[0] ? (crc >> 1) ^ fbfc_pkg::CRC_POLY : crc >> 1;
                end
            end
            o_rx_valid = 1'b1;
            o_rx_beat.data = b;
            o_rx_beat.last = (i == len - 1);
            o_rx_err = err && (i == len / 2);
            @(negedge i_clk);
        end
        // idle line shows no stale byte
        o_rx_valid = 1'b0;
        o_rx_beat.data = ~b;
        o_rx_beat.last = 1'b0;
        o_rx_err = 1'b0;
        // one idle edge, so a following call never re-raises valid at once
        @(negedge i_clk);
    endtask
endmodule

// [fbfc_pkg.sv]
/*
 * shared constants and carrier types for the store-and-forward frame
 * buffer with congestion control.
 * assumes a byte-wide receive stream from a mac on the same clock.
 */
package fbfc_pkg;

    // ------------------------------------------------------------
    // buffer geometry
    // ------------------------------------------------------------
    localparam int NSLOT = 4;   // frame slots in the store
    localparam int SLOT_W = 2;  // slot index width
    localparam int OFS_W = 11;  // byte offset inside a slot
    localparam int ADDR_W = 13; // store address width
    localparam int LEN_W = 12;  // frame length counter width
    localparam int CNT_W = 3;   // free slot / queue occupancy width
    localparam int NQUEUE = 2;  // output priority queues
    localparam int NPRIO = 8;   // 802.1p priority levels
    localparam logic [1:0] BUF_DEPTH = 2'h2; // egress skid entries

    // ------------------------------------------------------------
    // frame checks
    // ------------------------------------------------------------
    localparam logic [LEN_W-1:0] SLOT_BYTES = 12'h800; // bytes per slot
    localparam logic [LEN_W-1:0] MIN_LEN = 12'h040;    // 64 bytes
    localparam logic [LEN_W-1:0] MAX_LEN = 12'h5F2;    // 1522 bytes, tagged
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB88320;    // reflected crc-32
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3; // good-fcs remainder

    // ------------------------------------------------------------
    // priority tag position
    // ------------------------------------------------------------
    localparam logic [LEN_W-1:0] TPID_HI_IDX = 12'h00C;
    localparam logic [LEN_W-1:0] TPID_LO_IDX = 12'h00D;
    localparam logic [LEN_W-1:0] TCI_IDX = 12'h00E;
    localparam logic [7:0] TPID_HI = 8'h81;
    localparam logic [7:0] TPID_LO = 8'h00;
    localparam logic Q_LO = 1'b0;
    localparam logic Q_HI = 1'b1;

    // ------------------------------------------------------------
    // pause quanta
    // ------------------------------------------------------------
    localparam logic [15:0] PAUSE_XOFF = 16'hFFFF; // hold senders off
    localparam logic [15:0] PAUSE_XON = 16'h0000;  // release senders

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } beat_t;

    typedef struct packed {
        logic send;          // one-cycle request to the mac
        logic [15:0] quanta; // pause time to advertise
    } pause_t;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic [LEN_W-1:0] len;
    } qentry_t;

endpackage

// [frame_buffer_flow_control.sv]
/*
 * per-port frame admission, two priority queues and congestion control.
 * assumes a mac on i_clk delivering bytes with a last marker, a mac
 * transmitter that turns pause requests into pause frames, and static
 * configuration inputs from logic on the same clock.
 */
// Summary of operation
// [R1] whole frame stored before any forwarding
// [R2] forward only good length and crc
// [R3] pause frames when low, full duplex only
// [R4] resume normally after recovery, nothing dropped; a frame that starts with no free slot is still dropped
// [R5] force collision on half-duplex ports when low
// [R6] tagged high priority frames served first
// [R7] two queues, eight levels, configurable map
// [R8] low means free slots below threshold
`timescale 1ns/1ps
module frame_buffer_flow_control (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // configuration
    input wire logic i_full_duplex,
    input wire logic [fbfc_pkg::NPRIO-1:0] i_prio_map,
    input wire logic [fbfc_pkg::CNT_W-1:0] i_low_thresh,
    // receive stream
    input wire logic i_rx_valid,
    input wire fbfc_pkg::beat_t i_rx_beat,
    input wire logic i_rx_err,
    // transmit stream
    output logic o_tx_valid,
    output fbfc_pkg::beat_t o_tx_beat,
    input wire logic i_tx_ready,
    // congestion control
    output fbfc_pkg::pause_t o_pause,
    output logic o_force_col,
    output logic [fbfc_pkg::CNT_W-1:0] o_free_slots
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int b = 0; b < 8; b++) begin
            r = r[0] ? ((r >> 1) ^ fbfc_pkg::CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    typedef enum logic [1:0] {TX_IDLE, TX_READ, TX_DRAIN} tx_state_t;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [fbfc_pkg::NSLOT-1:0] free_q; // one bit per free slot
    logic [fbfc_pkg::CNT_W-1:0] free_cnt;
    logic any_free;
    logic [fbfc_pkg::SLOT_W-1:0] alloc_slot;
    logic rx_busy_q, rx_held_q, rx_bad_q, tpid_hi_q, rx_tag_q;
    logic [fbfc_pkg::SLOT_W-1:0] rx_slot_q, cur_slot;
    logic [fbfc_pkg::LEN_W-1:0] rx_cnt_q, idx, frame_len;
    logic [31:0] crc_q, crc_cur;
    logic [2:0] rx_prio_q;
    logic first, cur_held, cur_bad, end_frame, good, drop_free, push_sel, mem_we;
    logic pick_hi; // high queue has a frame waiting
    tx_state_t tx_state_q;
    logic [fbfc_pkg::SLOT_W-1:0] tx_slot_q;
    logic [fbfc_pkg::LEN_W-1:0] tx_len_q, rd_idx_q;
    logic tx_queue_q, tx_free, inflight_q, inflight_last_q, issue, pick;
    logic [7:0] mem_rdata;
    fbfc_pkg::qentry_t q_mem [fbfc_pkg::NQUEUE][fbfc_pkg::NSLOT];
    logic [fbfc_pkg::SLOT_W-1:0] q_wp_q [fbfc_pkg::NQUEUE];
    logic [fbfc_pkg::SLOT_W-1:0] q_rp_q [fbfc_pkg::NQUEUE];
    logic [fbfc_pkg::CNT_W-1:0] q_cnt_q [fbfc_pkg::NQUEUE];
    logic [fbfc_pkg::NQUEUE-1:0] q_push, q_pop;
    fbfc_pkg::beat_t buf_q [2]; // two-entry egress skid buffer
    logic buf_wp_q, buf_rp_q, buf_pop;
    logic [1:0] buf_cnt_q, occ;
    logic low_q, low_d;

    // ------------------------------------------------------------
    // free slot accounting
    // ------------------------------------------------------------
    // popcount and lowest free slot, searched from the top so the
    // last assignment is the lowest index
    always_comb begin
        free_cnt = '0;
        alloc_slot = '0;
        for (int s = fbfc_pkg::NSLOT - 1; s >= 0; s--) begin
            free_cnt = free_cnt + {{(fbfc_pkg::CNT_W-1){1'b0}}, free_q[s]};
            if (free_q[s]) begin
                alloc_slot = fbfc_pkg::SLOT_W'(s);
            end
        end
    end
    assign any_free = |free_q;
    assign o_free_slots = free_cnt;

    // alloc clears a bit before the frees set one, so a one-byte frame
    // that is dropped at once gives its slot straight back
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            free_q <= '1;
        end else begin
            free_q <= (free_q
                & ~((i_rx_valid && first && any_free) ? (fbfc_pkg::NSLOT'(1) << alloc_slot) : '0))
                | (drop_free ? (fbfc_pkg::NSLOT'(1) << cur_slot) : '0)
                | (tx_free ? (fbfc_pkg::NSLOT'(1) << tx_slot_q) : '0);
        end
    end

    // ------------------------------------------------------------
    // receive side: store and inspect
    // ------------------------------------------------------------
    assign first = !rx_busy_q;
    assign idx = first ? '0 : rx_cnt_q;
    assign frame_len = idx + fbfc_pkg::LEN_W'(1);
    assign cur_held = first ? any_free : rx_held_q; // no slot: frame is lost
    assign cur_slot = first ? alloc_slot : rx_slot_q;
    assign crc_cur = crc_byte(first ? fbfc_pkg::CRC_INIT : crc_q, i_rx_beat.data);
    // frames past SLOT_BYTES stop writing and are marked bad
    assign cur_bad = (!first && rx_bad_q) || i_rx_err || (idx >= fbfc_pkg::SLOT_BYTES);
    assign mem_we = i_rx_valid && cur_held && !cur_bad;
    assign end_frame = i_rx_valid && i_rx_beat.last;
    // judged only once the last byte is in the store
    assign good = end_frame && cur_held && !cur_bad && (crc_cur == fbfc_pkg::CRC_RESIDUE)
        && (frame_len >= fbfc_pkg::MIN_LEN) && (frame_len <= fbfc_pkg::MAX_LEN); // R1 R2
    assign drop_free = end_frame && cur_held && !good; // R2
    assign push_sel = rx_tag_q ? i_prio_map[rx_prio_q] : fbfc_pkg::Q_LO; // R6 R7

    // frame progress, crc and tag capture
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_busy_q <= 1'b0;
            rx_held_q <= 1'b0;
            rx_bad_q <= 1'b0;
            rx_slot_q <= '0;
            rx_cnt_q <= '0;
            crc_q <= fbfc_pkg::CRC_INIT;
            tpid_hi_q <= 1'b0;
            rx_tag_q <= 1'b0;
            rx_prio_q <= '0;
        end else if (i_rx_valid) begin
            rx_busy_q <= !i_rx_beat.last;
            rx_held_q <= cur_held;
            rx_bad_q <= cur_bad;
            rx_slot_q <= cur_slot;
            rx_cnt_q <= frame_len;
            crc_q <= crc_cur;
            if (first) begin
                rx_tag_q <= 1'b0;
            end
            if (idx == fbfc_pkg::TPID_HI_IDX) begin
                tpid_hi_q <= (i_rx_beat.data == fbfc_pkg::TPID_HI);
            end
            if (idx == fbfc_pkg::TPID_LO_IDX) begin
                rx_tag_q <= tpid_hi_q && (i_rx_beat.data == fbfc_pkg::TPID_LO);
            end
            if (idx == fbfc_pkg::TCI_IDX) begin
                rx_prio_q <= i_rx_beat.data[7:5];
            end
        end
    end

    // ------------------------------------------------------------
    // store
    // ------------------------------------------------------------
    frame_store u_store (
        .i_clk(i_clk),
        .i_we(mem_we),
        .i_waddr({cur_slot, idx[fbfc_pkg::OFS_W-1:0]}),
        .i_wdata(i_rx_beat.data),
        .i_re(issue),
        .i_raddr({tx_slot_q, rd_idx_q[fbfc_pkg::OFS_W-1:0]}),
        .o_rdata(mem_rdata)
    );

    // ------------------------------------------------------------
    // priority queues of finished frames
    // ------------------------------------------------------------
    // occupancy step of one, widened to the counter
    function automatic logic [fbfc_pkg::CNT_W-1:0] cnt_one(input logic b);
        return {{(fbfc_pkg::CNT_W-1){1'b0}}, b};
    endfunction

    // high queue wins whenever it has a frame; a plain net, so every
    // reader sees the count change without relying on function sensitivity
    assign pick_hi = (q_cnt_q[fbfc_pkg::Q_HI] != '0); // R6

    // a queue never holds more than the slot count, so it cannot overflow
    generate
        for (genvar g = 0; g < fbfc_pkg::NQUEUE; g++) begin : g_queue
            assign q_push[g] = good && (push_sel == 1'(g)); // R7
            assign q_pop[g] = pick && (pick_hi == 1'(g));
            always_ff @(posedge i_clk or negedge i_nrst) begin
                if (!i_nrst) begin
                    q_wp_q[g] <= '0;
                    q_rp_q[g] <= '0;
                    q_cnt_q[g] <= '0;
                end else begin
                    if (q_push[g]) begin
                        q_mem[g][q_wp_q[g]] <= '{slot: cur_slot, len: frame_len};
                        q_wp_q[g] <= q_wp_q[g] + fbfc_pkg::SLOT_W'(1);
                    end
                    if (q_pop[g]) begin
                        q_rp_q[g] <= q_rp_q[g] + fbfc_pkg::SLOT_W'(1);
                    end
                    q_cnt_q[g] <= q_cnt_q[g] + cnt_one(q_push[g]) - cnt_one(q_pop[g]);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // transmit side: read finished frames into the skid buffer
    // ------------------------------------------------------------
    assign pick = (tx_state_q == TX_IDLE) && ((q_cnt_q[0] != '0) || (q_cnt_q[1] != '0));
    assign occ = buf_cnt_q + {1'b0, inflight_q};
    // a read is only issued when its byte is sure of a place
    assign issue = (tx_state_q == TX_READ) && ((occ < fbfc_pkg::BUF_DEPTH) || buf_pop);
    assign tx_free = (tx_state_q == TX_DRAIN) && !inflight_q;

    // frame walk
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_state_q <= TX_IDLE;
            tx_slot_q <= '0;
            tx_len_q <= '0;
            tx_queue_q <= fbfc_pkg::Q_LO;
            rd_idx_q <= '0;
        end else begin
            unique case (tx_state_q)
                TX_IDLE: begin
                    if (pick) begin
                        tx_queue_q <= pick_hi;
                        tx_slot_q <= q_mem[pick_hi][q_rp_q[pick_hi]].slot;
                        tx_len_q <= q_mem[pick_hi][q_rp_q[pick_hi]].len;
                        rd_idx_q <= '0;
                        tx_state_q <= TX_READ;
                    end
                end
                TX_READ: begin
                    if (issue) begin
                        rd_idx_q <= rd_idx_q + fbfc_pkg::LEN_W'(1);
                        if (rd_idx_q == tx_len_q - fbfc_pkg::LEN_W'(1)) begin
                            tx_state_q <= TX_DRAIN;
                        end
                    end
                end
                TX_DRAIN: begin
                    if (!inflight_q) begin
                        tx_state_q <= TX_IDLE; // slot returned this cycle
                    end
                end
            endcase
        end
    end

    // read in flight marker
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            inflight_q <= 1'b0;
            inflight_last_q <= 1'b0;
        end else begin
            inflight_q <= issue;
            inflight_last_q <= issue && (rd_idx_q == tx_len_q - fbfc_pkg::LEN_W'(1));
        end
    end

    // ------------------------------------------------------------
    // egress skid buffer
    // ------------------------------------------------------------
    assign buf_pop = o_tx_valid && i_tx_ready;
    assign o_tx_valid = (buf_cnt_q != 2'h0);
    assign o_tx_beat = buf_q[buf_rp_q];

    // receiver stall simply holds the head; reads stop via occ
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_cnt_q <= 2'h0;
        end else begin
            if (inflight_q) begin
                buf_q[buf_wp_q] <= '{data: mem_rdata, last: inflight_last_q};
                buf_wp_q <= !buf_wp_q;
            end
            if (buf_pop) begin
                buf_rp_q <= !buf_rp_q;
            end
            buf_cnt_q <= buf_cnt_q + {1'b0, inflight_q} - {1'b0, buf_pop};
        end
    end

    // ------------------------------------------------------------
    // congestion control
    // ------------------------------------------------------------
    assign low_d = (free_cnt < i_low_thresh); // R8
    assign o_force_col = low_q && !i_full_duplex; // R5

    // pause requests go out on entry to and exit from low space, in full duplex only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            low_q <= 1'b0;
            o_pause <= '0;
        end else begin
            low_q <= low_d;
            o_pause.send <= (low_d != low_q) && i_full_duplex; // R3 R4
            o_pause.quanta <= low_d ? fbfc_pkg::PAUSE_XOFF : fbfc_pkg::PAUSE_XON; // R3 R4
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    a_no_cut_through: assert property ( // R1
        (tx_state_q != TX_IDLE) |-> !(rx_busy_q && rx_held_q && rx_slot_q == tx_slot_q))
        else $error("slot read while still being received");
    a_good_length: assert property ( // R2
        (|q_push) |-> (frame_len >= fbfc_pkg::MIN_LEN && frame_len <= fbfc_pkg::MAX_LEN
            && crc_cur == fbfc_pkg::CRC_RESIDUE))
        else $error("bad frame queued");
    a_pause_duplex: assert property ( // R3
        o_pause.send |-> $past(i_full_duplex))
        else $error("pause sent on half duplex");
    a_pause_entry: assert property ( // R3
        (low_d && !low_q && i_full_duplex) |=> o_pause.send
            && o_pause.quanta == fbfc_pkg::PAUSE_XOFF)
        else $error("no xoff pause on entering low space");
    a_pause_exit: assert property ( // R4
        (!low_d && low_q && i_full_duplex) |=> o_pause.send
            && o_pause.quanta == fbfc_pkg::PAUSE_XON)
        else $error("no xon pause on recovery");
    a_col_half: assert property ( // R5
        (low_d && !i_full_duplex) |=> ##0 (o_force_col || i_full_duplex))
        else $error("no forced collision while low");
    a_prio_order: assert property ( // R6
        (pick && q_cnt_q[1] != '0) |=> tx_queue_q == 1'b1)
        else $error("low queue served before high");
    a_prio_map: assert property ( // R7
        (good && rx_tag_q) |-> q_push[i_prio_map[rx_prio_q]])
        else $error("tagged frame in wrong queue");
    a_low_thresh: assert property ( // R8
        (free_cnt < i_low_thresh) |=> low_q)
        else $error("low space not flagged");
    a_buf_bound: assert property (
        buf_cnt_q <= fbfc_pkg::BUF_DEPTH && occ <= fbfc_pkg::BUF_DEPTH)
        else $error("skid buffer overrun");

endmodule

// [frame_buffer_flow_control_tb.sv]
/*
 * self-checking bench for the frame buffer with congestion control.
 * assumes the link partner model beside it and a random sink.
 */
`timescale 1ns/1ps
module frame_buffer_flow_control_tb;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_full_duplex = 1'b1;
    logic [fbfc_pkg::NPRIO-1:0] i_prio_map = 8'h00;
    logic [fbfc_pkg::CNT_W-1:0] i_low_thresh = 3'h0;
    logic i_rx_valid;
    fbfc_pkg::beat_t i_rx_beat;
    logic i_rx_err;
    logic o_tx_valid;
    fbfc_pkg::beat_t o_tx_beat;
    logic i_tx_ready = 1'b0;
    fbfc_pkg::pause_t o_pause;
    logic o_force_col;
    logic [fbfc_pkg::CNT_W-1:0] o_free_slots;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0; // watchdog count
    bit rdy_en = 1'b0; // sink may accept
    int nb = 0; // beats of the frame on tx
    logic [7:0] cur_id; // first byte names a frame
    logic [7:0] nid = 8'h01;
    logic [7:0] got[$];
    logic [7:0] exp[$];
    int n_xoff = 0;
    int n_xon = 0;
    int n_hd_pause = 0;
    int rx_last_cyc = 0;
    int tx_first_cyc = 0;

    frame_buffer_flow_control u_frame_buffer_flow_control (
        .i_clk(i_clk), .i_nrst(i_nrst), .i_full_duplex(i_full_duplex),
        .i_prio_map(i_prio_map), .i_low_thresh(i_low_thresh),
        .i_rx_valid(i_rx_valid), .i_rx_beat(i_rx_beat), .i_rx_err(i_rx_err),
        .o_tx_valid(o_tx_valid), .o_tx_beat(o_tx_beat), .i_tx_ready(i_tx_ready),
        .o_pause(o_pause), .o_force_col(o_force_col), .o_free_slots(o_free_slots));

    fbfc_link_partner u_fbfc_link_partner (
        .i_clk(i_clk), .i_pause(o_pause), .o_rx_valid(i_rx_valid),
        .o_rx_beat(i_rx_beat), .o_rx_err(i_rx_err));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    // sink stalls at random so the skid buffer is exercised
    always @(negedge i_clk) begin
        i_tx_ready <= rdy_en && ($urandom_range(3) != 0);
    end

    // ------------------------------------------------------------
    // monitors
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (i_rx_valid && i_rx_beat.last) rx_last_cyc <= cyc;
        if (o_tx_valid && i_tx_ready) begin
            if (nb == 0) begin
                cur_id = o_tx_beat.data;
                tx_first_cyc <= cyc;
            end
            nb = o_tx_beat.last ? 0 : nb + 1;
            if (o_tx_beat.last) got.push_back(cur_id);
        end
        if (o_pause.send === 1'b1) begin
            if (o_pause.quanta === 16'hFFFF) n_xoff++;
            else n_xon++;
            if (!i_full_duplex) n_hd_pause++;
        end
        if (cyc == 60000) begin
            n_fail++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] %s expected %0h seen %0h", what, want, seen);
        end
    endtask

    // only whole frames of legal length, good fcs and no error go out
    function automatic bit is_good(int len, bit bad, bit err);
        return len >= int'(fbfc_pkg::MIN_LEN) && len <= int'(fbfc_pkg::MAX_LEN) && !bad && !err;
    endfunction

    task automatic tx_frame(input int len, input bit tag, input logic [2:0] p,
                            input bit bad, input bit err);
        logic [7:0] id;
        id = nid;
        nid++;
        if (is_good(len, bad, err)) exp.push_back(id);
        u_fbfc_link_partner.send(id, len, tag, p, bad, err);
    endtask

    task automatic drain();
        rdy_en = 1'b1;
        for (int i = 0; i < 20000 && got.size() < exp.size(); i++) @(negedge i_clk);
        repeat (8) @(negedge i_clk);
        check("frames out", got.size(), exp.size());
        foreach (exp[i]) check("frame id", got[i], exp[i]);
        got.delete();
        exp.delete();
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(25));
        repeat (5) @(negedge i_clk);
        i_nrst = 1'b1;
        @(negedge i_clk);
        check("free at reset", o_free_slots, 3'h4);
        // longest frame: nothing leaves before its last byte arrives
        rdy_en = 1'b1;
        tx_frame(1522, 0, 3'h0, 0, 0);
        drain();
        check("tx after rx end", tx_first_cyc > rx_last_cyc, 1);
        // bad fcs, short, long, errored, then both length limits
        tx_frame(100, 0, 3'h0, 1, 0);
        tx_frame(63, 0, 3'h0, 0, 0);
        tx_frame(1523, 1, 3'h5, 0, 0);
        tx_frame(100, 0, 3'h0, 0, 1);
        tx_frame(64, 0, 3'h0, 0, 0);
        tx_frame(1522, 1, 3'h7, 0, 0);
        drain();
        for (int k = 0; k < 10; k++) begin
            tx_frame(56 + $urandom_range(1480), 1'($urandom_range(1)),
                     3'($urandom_range(7)), $urandom_range(9) == 0,
                     $urandom_range(9) == 0);
            drain();
        end
        // every priority level against a random queue map
        i_prio_map = 8'($urandom());
        for (int p = 0; p < 8; p++) begin
            rdy_en = 1'b0;
            tx_frame(64 + $urandom_range(60), 0, 3'h0, 0, 0);
            tx_frame(80, 0, 3'h0, 0, 0);
            tx_frame(80, 1, 3'(p), 0, 0);
            if (i_prio_map[p]) begin
                exp[1] = exp[2];
                exp[2] = exp[1] - 8'h01;
            end
            drain();
        end
        // full duplex: low space sends xoff, recovery sends xon
        i_low_thresh = 3'h2;
        rdy_en = 1'b0;
        repeat (3) tx_frame(70, 0, 3'h0, 0, 0);
        repeat (4) @(negedge i_clk);
        check("free when low", o_free_slots, 3'h1);
        check("xoff sent", n_xoff, 1);
        check("no collision full", o_force_col, 1'b0);
        fork
            tx_frame(70, 0, 3'h0, 0, 0);
        join_none
        repeat (4) @(negedge i_clk);
        drain();
        // the held frame takes a slot again, so low may come and go twice
        check("xon sent", n_xon, n_xoff);
        // half duplex: collision instead of pause
        i_full_duplex = 1'b0;
        rdy_en = 1'b0;
        repeat (3) tx_frame(70, 0, 3'h0, 0, 0);
        repeat (4) @(negedge i_clk);
        check("collision when low", o_force_col, 1'b1);
        drain();
        check("collision released", o_force_col, 1'b0);
        check("pause in half", n_hd_pause, 0);
        close_out();
    end
endmodule

// [frame_store.sv]
/*
 * frame store: simple dual-port byte memory with registered read data.
 * assumes one writer and one reader on the same clock.
 */
`timescale 1ns/1ps
module frame_store (
    // clock
    input wire logic i_clk,
    // write port
    input wire logic i_we,
    input wire logic [fbfc_pkg::ADDR_W-1:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // read port
    input wire logic i_re,
    input wire logic [fbfc_pkg::ADDR_W-1:0] i_raddr,
    output logic [7:0] o_rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] mem [0:(1 << fbfc_pkg::ADDR_W)-1]; // no reset, contents only

    // write side
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // read data registered, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule
